// [core/ext_bus_arbiter.sv]
`timescale 1ns/1ps
`include "bus_arbiter_consts.svh"

module ext_bus_arbiter
	import bus_arbiter_pkg::*;
#(
	parameter int NUM_PEER_LINES = 2
) (
	input  wire logic       clk,                    // core clock, 250 MHz
	input  wire logic       rst,                    // async reset, active high
	input  wire logic [1:0] processor_identity,     // strapped identity
	input  wire logic       host_bus_request_n,     // host wants the bus
	input  wire logic       chip_select_n,          // host selects this device
	input  wire logic       host_wait,              // internal side not ready for host
	input  wire logic       ack_active_drive_bit,   // config: ack actively driven
	input  wire logic       suspend_bus_float_n,    // suspend bus, active low
	input  wire logic       core_bus_req,           // core wants an external access
	input  wire logic       dma_bus_req,            // background dma wants the bus
	input  wire logic       core_priority_req,      // core asks to pre-empt dma
	input  wire logic [1:0] peer_bus_request_n_i,   // wired level of request lines
	output logic      [1:0] peer_bus_request_n_o,   // request line drive value
	output logic      [1:0] peer_bus_request_oe_n,  // request line enable, low drives
	input  wire logic       core_priority_line_i,   // wired priority level
	output logic            core_priority_line_o,   // priority drive value
	output logic            core_priority_line_oe_n, // priority enable, low drives
	output logic            host_bus_grant_n,       // grant to host
	output logic            host_bus_grant_oe_n,    // grant enable, low drives
	output logic            host_access_ack_o,      // host ack value
	output logic            host_access_ack_oe_n,   // host ack enable, low drives
	output logic            bus_oe_n,               // addr/data/select/strobe enable
	output logic            sdram_ctl_oe_n,         // sdram control enable
	output logic            is_master,              // this device owns the bus
	output logic            access_stall,           // external access must wait
	input  wire logic       ext_dma_request_1_n,    // external dma request 1
	input  wire logic       ext_dma_request_2_n,    // external dma request 2
	output logic            dma_req_ch9,            // request to channel 9
	output logic            dma_req_ch8,            // request to channel 8
	input  wire logic       dma_grant_ch9,          // grant from channel 9
	input  wire logic       dma_grant_ch8,          // grant from channel 8
	output logic            ext_dma_grant_1_n,      // external dma grant 1
	output logic            ext_dma_grant_2_n,      // external dma grant 2
	output logic            ext_dma_grant_oe_n      // dma grant enable, low drives
);

	// the request line decode and ownership swap assume exactly two lines
	if (NUM_PEER_LINES != 2) begin : g_bad_lines
		$error("only two peer request lines are supported");
	end

	role_e  role_q;
	role_e  role_d;
	ident_t ident_q;
	logic   ident_taken_q;
	logic   master_line_q;
	logic   master_line_d;
	logic   suspend_q;
	logic   host_req;
	logic   single;
	logic   my_line;
	logic   other_cpa;
	logic   want_bus;
	logic   ack_drive;

	assign host_req = !host_bus_request_n;

	// identity caught once after reset release; a strap must not move later
	// capture identity once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ident_q       <= `ID_SINGLE;
			ident_taken_q <= 1'b0;
		end else if (!ident_taken_q) begin
			ident_q       <= processor_identity;
			ident_taken_q <= 1'b1;
		end
	end

	assign single  = (ident_q != `ID_FIRST) && (ident_q != `ID_SECOND);
	assign my_line = (ident_q == `ID_SECOND);

	assign other_cpa = !core_priority_line_i && core_priority_line_oe_n;

	// dma backs off while another slave core claims priority
	// core pre-empts dma
	assign want_bus = core_bus_req || (dma_bus_req && !other_cpa);

	generate
		for (genvar i = 0; i < NUM_PEER_LINES; i++) begin : g_req_line
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					peer_bus_request_n_o[i]  <= 1'b1;
					peer_bus_request_oe_n[i] <= 1'b1;
				end else begin
					peer_bus_request_n_o[i]  <= !want_bus;
					peer_bus_request_oe_n[i] <= single || (my_line != 1'(i));
				end
			end
		end
	endgenerate

	// mastership passes only when the holder's line goes idle, so both ends
	// track the same owner without extra wires
	always_comb begin
		master_line_d = master_line_q;
		if (!host_req && role_q != ROLE_GRANT) begin
			if (peer_bus_request_n_i[master_line_q] &&
			    !peer_bus_request_n_i[!master_line_q]) begin
				master_line_d = !master_line_q;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			master_line_q <= 1'b0;
		end else begin
			master_line_q <= master_line_d;
		end
	end

	always_comb begin
		role_d = role_q;
		case (role_q)
			ROLE_SLAVE: begin
				// no mastership before the strap is read: the reset value 00 would
				// make a second-line device look single and drive the bus for a cycle
				if (ident_taken_q && (single || master_line_d == my_line)) begin
					role_d = ROLE_MASTER;
				end
			end
			ROLE_MASTER: begin
				if (host_req) begin
					role_d = ROLE_GRANT;
				end else if (!single && master_line_d != my_line) begin
					role_d = ROLE_SLAVE;
				end
			end
			ROLE_GRANT: begin
				if (!host_req) begin
					role_d = ROLE_MASTER;
				end
			end
			default: role_d = ROLE_SLAVE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			role_q <= ROLE_SLAVE;
		end else begin
			role_q <= role_d;
		end
	end

	assign is_master = (role_q != ROLE_SLAVE);

	assign host_bus_grant_n = (role_q != ROLE_GRANT);
	assign host_bus_grant_oe_n = !is_master;

	// suspend takes effect from the following cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			suspend_q <= 1'b0;
		end else begin
			suspend_q <= !suspend_bus_float_n;
		end
	end

	assign bus_oe_n = (role_q != ROLE_MASTER) || suspend_q;
	assign sdram_ctl_oe_n = 1'b0;
	assign access_stall = (core_bus_req || dma_bus_req) && bus_oe_n;

	assign core_priority_line_o    = 1'b0;
	assign core_priority_line_oe_n = !(core_priority_req && !is_master && !single);

	assign ack_drive = !chip_select_n && host_req;

	// open-drain can only pull low, so ready is the pull-up releasing
	// wait states by deassert
	always_comb begin
		host_access_ack_o    = !host_wait;
		host_access_ack_oe_n = 1'b1;
		if (ack_drive) begin
			if (ack_active_drive_bit) begin
				host_access_ack_oe_n = 1'b0;
			end else begin
				host_access_ack_o    = 1'b0;
				host_access_ack_oe_n = !host_wait;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dma_req_ch9       <= 1'b0;
			dma_req_ch8       <= 1'b0;
			ext_dma_grant_1_n <= 1'b1;
			ext_dma_grant_2_n <= 1'b1;
		end else begin
			dma_req_ch9       <= !ext_dma_request_1_n;
			dma_req_ch8       <= !ext_dma_request_2_n;
			ext_dma_grant_1_n <= !dma_grant_ch9;
			ext_dma_grant_2_n <= !dma_grant_ch8;
		end
	end

	assign ext_dma_grant_oe_n = bus_oe_n;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	grant_after_request_a: assert property (
		role_q == ROLE_MASTER && host_req |=> !host_bus_grant_n && !host_bus_grant_oe_n)
		else $error("host grant not asserted after request");

	float_while_granted_a: assert property (
		!host_bus_grant_n |-> bus_oe_n && $past(host_req))
		else $error("bus driven while host is granted");

	sdram_kept_driven_a: assert property (
		!host_bus_grant_n |-> !sdram_ctl_oe_n)
		else $error("sdram control floated during host ownership");

	host_beats_peer_a: assert property (
		host_req && role_q == ROLE_GRANT |=> $stable(master_line_q))
		else $error("peer mastership moved under host request");

	grant_release_a: assert property (
		role_q == ROLE_GRANT && !host_req |=> host_bus_grant_n)
		else $error("grant not removed after request release");

	grant_master_only_a: assert property (
		!host_bus_grant_oe_n |-> role_q != ROLE_SLAVE)
		else $error("slave drives host grant");

	ack_window_a: assert property (
		!host_access_ack_oe_n |-> !chip_select_n && !host_bus_request_n)
		else $error("ack driven outside select and request");

	ack_open_drain_a: assert property (
		!ack_active_drive_bit && !host_access_ack_oe_n |-> !host_access_ack_o && host_wait)
		else $error("open-drain ack drove high or low without wait");

	ack_wait_state_a: assert property (
		ack_drive && host_wait |-> !host_access_ack_o && !host_access_ack_oe_n)
		else $error("wait state not signalled on ack");

	own_line_only_a: assert property (
		ident_taken_q && ident_q == `ID_FIRST |=> peer_bus_request_oe_n[1])
		else $error("drove a request line not owned");

	suspend_float_a: assert property (
		!suspend_bus_float_n |=> bus_oe_n && ((core_bus_req || dma_bus_req) -> access_stall))
		else $error("bus not floated after suspend");

	priority_open_drain_a: assert property (
		!core_priority_line_oe_n |-> !core_priority_line_o && !is_master)
		else $error("priority line driven high or by master");

	dma_map_a: assert property (
		##1 dma_req_ch9 == !$past(ext_dma_request_1_n) &&
		ext_dma_grant_2_n == !$past(dma_grant_ch8))
		else $error("dma pin to channel mapping broken");

	slave_until_ident_a: assert property (
		!ident_taken_q |=> !is_master)
		else $error("mastership taken before identity was known");

	single_lines_idle_a: assert property (
		ident_taken_q && single |=> peer_bus_request_oe_n == 2'h3)
		else $error("single processor drove a request line");

	dma_yields_priority_a: assert property (
		!core_bus_req && other_cpa |=> peer_bus_request_n_o == 2'h3)
		else $error("dma kept requesting while priority line held");

	ack_active_drive_a: assert property (
		ack_drive && ack_active_drive_bit |->
		!host_access_ack_oe_n && host_access_ack_o == !host_wait)
		else $error("active ack not driven to ready level");

	owner_kept_a: assert property (
		!peer_bus_request_n_i[master_line_q] |=> $stable(master_line_q))
		else $error("ownership moved while owner line was low");

	grant_held_a: assert property (
		role_q == ROLE_GRANT && host_req |=> !host_bus_grant_n)
		else $error("grant dropped while host still requests");

endmodule // ext_bus_arbiter

// [core/bus_arbiter_consts.svh]
// Functional notes
// - master releases bus, then asserts host grant; the code does both on the same edge
// - released bus floats address, data, selects, strobes
// - sdram control stays driven while host owns
// - host request beats every peer request
// - grant held until host request withdrawn
// - only the bus master drives host grant
// - ack deasserted to insert host wait states
// - ack open-drain after reset, active drive optional
// - ack driven only with select and request
// - drive own request line, monitor the other
// - identity 01 first, 10 second, 00 single
// - slave core priority pre-empts background dma
// - priority line open-drain, wired, reads high idle
// - dma request/grant 1 channel 9, 2 channel 8
// - suspend input floats bus next cycle, stalls access
`ifndef BUS_ARBITER_CONSTS_SVH
`define BUS_ARBITER_CONSTS_SVH
`define ID_SINGLE      2'h0
`define ID_FIRST       2'h1
`define ID_SECOND      2'h2
`define DMA_CH_PAIR_1  4'h9
`define DMA_CH_PAIR_2  4'h8
`define GRANT_DELAY    1
`endif

// [core/bus_arbiter_pkg.sv]
package bus_arbiter_pkg;
	typedef enum logic [2:0] {
		ROLE_SLAVE  = 3'b001,
		ROLE_MASTER = 3'b010,
		ROLE_GRANT  = 3'b100
	} role_e;
	typedef logic [1:0] ident_t;
endpackage

// [dv/host_model.sv]
`timescale 1ns/1ps
module host_model (
	input  wire logic clk,          // core clock
	input  wire logic want,         // bench asks for the bus
	input  wire logic sel,          // bench asks for an access
	input  wire logic grant_n,      // grant from the device
	output logic      req_n = 1'b1, // host bus request
	output logic      cs_n = 1'b1,  // chip select
	output logic      owns          // host may drive the bus
);
	always_ff @(posedge clk) begin
		req_n <= !want;
	end
	always_ff @(posedge clk) begin
		cs_n <= !sel;
	end
	// drive only between grant and withdrawal
	assign owns = !grant_n && !req_n && want;
endmodule // host_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic       clk, rst, host_wait, ack_active_drive_bit, suspend_bus_float_n, want, sel;
	logic       core_bus_req, dma_bus_req, core_priority_req, owns, core_priority_line_i;
	logic       ext_dma_request_1_n, ext_dma_request_2_n, dma_grant_ch9, dma_grant_ch8;
	logic       host_bus_request_n, chip_select_n, core_priority_line_o, core_priority_line_oe_n;
	logic       host_bus_grant_n, host_bus_grant_oe_n, host_access_ack_o, host_access_ack_oe_n;
	logic       bus_oe_n, sdram_ctl_oe_n, is_master, access_stall, dma_req_ch9, dma_req_ch8;
	logic       ext_dma_grant_1_n, ext_dma_grant_2_n, ext_dma_grant_oe_n, cpa_drv_n;
	logic [3:0] dma_exp, dma_q[$];
	logic [1:0] processor_identity, peer_drv_n, peer_bus_request_n_i;
	logic [1:0] peer_bus_request_n_o, peer_bus_request_oe_n;
	int         errors, checks_done, seed;

	// pull-ups on both wired lines
	assign core_priority_line_i = cpa_drv_n & (core_priority_line_oe_n | core_priority_line_o);
	assign peer_bus_request_n_i = peer_drv_n & (peer_bus_request_oe_n | peer_bus_request_n_o);

	ext_bus_arbiter ext_bus_arbiter_i (.clk, .rst, .processor_identity, .host_bus_request_n,
		.chip_select_n, .host_wait, .ack_active_drive_bit, .suspend_bus_float_n, .core_bus_req,
		.dma_bus_req, .core_priority_req, .peer_bus_request_n_i, .peer_bus_request_n_o,
		.peer_bus_request_oe_n, .core_priority_line_i, .core_priority_line_o,
		.core_priority_line_oe_n, .host_bus_grant_n, .host_bus_grant_oe_n, .host_access_ack_o,
		.host_access_ack_oe_n, .bus_oe_n, .sdram_ctl_oe_n, .is_master, .access_stall,
		.ext_dma_request_1_n, .ext_dma_request_2_n, .dma_req_ch9, .dma_req_ch8, .dma_grant_ch9,
		.dma_grant_ch8, .ext_dma_grant_1_n, .ext_dma_grant_2_n, .ext_dma_grant_oe_n);

	host_model host_model_i (.clk, .want, .sel, .grant_n(host_bus_grant_n),
		.req_n(host_bus_request_n), .cs_n(chip_select_n), .owns);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic do_reset(input logic [1:0] id, input int n);
		rst = 1'b1;
		processor_identity = id;
		step(n);
		rst = 1'b0;
		step(2);
	endtask

	// a hung handshake ends the run here
	initial begin
		#60000;
		errors++;
		close_out();
	end

	initial begin
		{want, sel, host_wait, ack_active_drive_bit} = 4'h0;
		{core_bus_req, dma_bus_req, core_priority_req} = 3'h0;
		{ext_dma_request_1_n, ext_dma_request_2_n, dma_grant_ch9, dma_grant_ch8} = 4'hC;
		suspend_bus_float_n = 1'b1;
		peer_drv_n = 2'h3;
		cpa_drv_n = 1'b1;
		errors = 0;
		checks_done = 0;
		rst = 1'b1;
		processor_identity = 2'h0;
		seed = $urandom(32'h73993619);
		step(1);
		chk(host_bus_grant_oe_n, 1'b1);
		chk(sdram_ctl_oe_n, 1'b0);
		do_reset(2'h0, 11);
		chk(is_master, 1'b1);
		// back to back takeovers with random wait states inside each
		for (int i = 0; i < 3; i++) begin
			want = 1'b1;
			sel = 1'b1;
			step(1);
			chk(host_bus_grant_n, 1'b1);
			step(1);
			chk(host_bus_grant_n, 1'b0);
			chk(host_bus_grant_oe_n, 1'b0);
			chk(bus_oe_n, 1'b1);
			chk(sdram_ctl_oe_n, 1'b0);
			chk(owns, 1'b1);
			repeat (8) begin
				{host_wait, ack_active_drive_bit} = 2'($urandom);
				#1;
				chk(host_access_ack_oe_n, ack_active_drive_bit ? 1'b0 : !host_wait);
				if (ack_active_drive_bit) chk(host_access_ack_o, !host_wait);
				else chk(host_access_ack_o, 1'b0);
				step(1);
			end
			sel = 1'b0;
			step(2);
			chk(host_access_ack_oe_n, 1'b1);
			want = 1'b0;
			step(1);
			chk(host_bus_grant_n, 1'b0);
			chk(owns, 1'b0);
			step(1);
			chk(host_bus_grant_n, 1'b1);
			chk(bus_oe_n, 1'b0);
		end
		// pin model: expected levels queued now, taken out one edge later
		repeat (16) begin
			{ext_dma_request_1_n, ext_dma_request_2_n, dma_grant_ch9, dma_grant_ch8} = 4'($urandom);
			dma_q.push_back({!ext_dma_request_1_n, !ext_dma_request_2_n,
				!dma_grant_ch9, !dma_grant_ch8});
			step(1);
			dma_exp = dma_q.pop_front();
			chk(dma_req_ch9, dma_exp[3]);
			chk(dma_req_ch8, dma_exp[2]);
			chk(ext_dma_grant_1_n, dma_exp[1]);
			chk(ext_dma_grant_2_n, dma_exp[0]);
		end
		chk(ext_dma_grant_oe_n, 1'b0);
		core_bus_req = 1'b1;
		suspend_bus_float_n = 1'b0;
		#1;
		chk(bus_oe_n, 1'b0);
		step(1);
		chk(bus_oe_n, 1'b1);
		chk(access_stall, 1'b1);
		chk(ext_dma_grant_oe_n, 1'b1);
		suspend_bus_float_n = 1'b1;
		step(2);
		chk(access_stall, 1'b0);
		core_bus_req = 1'b0;
		do_reset(2'h1, 12);
		chk(peer_bus_request_oe_n[1], 1'b1);
		chk(is_master, 1'b1);
		// background dma backs off while another core pulls the priority line
		dma_bus_req = 1'b1;
		step(1);
		chk(peer_bus_request_n_o[0], 1'b0);
		cpa_drv_n = 1'b0;
		step(1);
		chk(peer_bus_request_n_o[0], 1'b1);
		cpa_drv_n = 1'b1;
		dma_bus_req = 1'b0;
		do_reset(2'h2, 12);
		chk(peer_bus_request_oe_n[0], 1'b1);
		chk(is_master, 1'b0);
		core_priority_req = 1'b1;
		step(1);
		chk(core_priority_line_i, 1'b0);
		core_priority_req = 1'b0;
		step(1);
		chk(core_priority_line_i, 1'b1);
		// slave wins mastership once the first line stays idle
		core_bus_req = 1'b1;
		step(4);
		chk(peer_bus_request_oe_n[1], 1'b0);
		chk(peer_bus_request_n_o[1], 1'b0);
		chk(is_master, 1'b1);
		// host arrives as a peer starts requesting and this device lets go
		want = 1'b1;
		core_bus_req = 1'b0;
		peer_drv_n = 2'h2;
		step(2);
		chk(host_bus_grant_n, 1'b0);
		chk(is_master, 1'b1);
		want = 1'b0;
		step(3);
		chk(is_master, 1'b0);
		close_out();
	end
endmodule // tb_top
